// *** fault_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module fault_host(input wire logic mclk, output logic wr_en = 0, rd_en = 0,
   output logic [7:0] addr = 8'h00, wr_data = 8'h00);
   // Released write data is inverted so a stale value can never pass for a held one.
   task automatic acc(input logic w, input logic [7:0] a, d);
      @(posedge mclk) #1 {wr_en, rd_en, addr, wr_data} = {w, !w, a, d};
      @(posedge mclk) #1 {wr_en, rd_en, wr_data} = {2'b00, ~d};
   endtask
endmodule
`default_nettype wire

// *** fault_status_flags.sv ***
`timescale 1ns/10ps
`default_nettype none

module fault_status_flags (
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic detail_clear,
   input wire logic battery_below,
   input wire logic ref_input_lockout,
   input wire logic analog_supply_power_down,
   input wire logic ecc_uncorrected,
   input wire logic nvm_voltage_low,
   input wire logic nvm_data_invalid,
   input wire logic cold_reset_input_n,
   input wire logic watchdog_error,
   input wire logic otemp_fault,
   input wire logic otemp_warn,
   input wire logic [3:0] regulator_uv
);

   ////////////////////////////////////////////////////////////////////////////
   // Flag words as the host sees them.
   wire [7:0] latched_q;

   wire [3:0] live_q;

   wire [7:0] live_word;

   wire [7:0] set_vec;

   wire [7:0] clr_mask;

   // Registered edge history and output next values.
   logic batt_prev_q;

   logic batt_prev_d;

   logic [7:0] rd_data_d;

   logic detail_clear_d;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode. Only the latched register accepts writes; the live one is read-only.
   wire sel_latched = (addr == fault_status_pkg::latched_six_addr);

   wire sel_live = (addr == fault_status_pkg::live_one_addr);

   wire write_latched = wr_en && sel_latched;

   wire read_latched = rd_en && sel_latched;

   wire read_live = rd_en && sel_live;

   ////////////////////////////////////////////////////////////////////////////
   // Set conditions, one per latched flag.
   wire batt_edge = battery_below && !batt_prev_q;

   wire ref_lockout_set = ref_input_lockout;

   wire analog_pd_set = analog_supply_power_down;

   wire ecc_set = ecc_uncorrected;

   wire nvm_voltage_set = nvm_voltage_low;

   wire nvm_data_set = nvm_data_invalid;

   wire mem_err_set = ecc_set || nvm_voltage_set || nvm_data_set;

   // The cold reset input is a level, so the flag sets again each cycle the pin stays low.
   wire rst_trig_set = !cold_reset_input_n;

   wire wdog_set = watchdog_error;

   wire otemp_fault_set = otemp_fault;

   wire otemp_warn_set = otemp_warn;

   ////////////////////////////////////////////////////////////////////////////
   // Set and clear vectors in register bit order.
   assign set_vec[fault_status_pkg::batt_bit] = batt_edge;

   assign set_vec[fault_status_pkg::ref_lockout_bit] = ref_lockout_set;

   assign set_vec[fault_status_pkg::analog_pd_bit] = analog_pd_set;

   assign set_vec[fault_status_pkg::mem_err_bit] = mem_err_set;

   assign set_vec[fault_status_pkg::rst_trig_bit] = rst_trig_set;

   assign set_vec[fault_status_pkg::wdog_bit] = wdog_set;

   assign set_vec[fault_status_pkg::otemp_fault_bit] = otemp_fault_set;

   assign set_vec[fault_status_pkg::otemp_warn_bit] = otemp_warn_set;

   assign clr_mask = write_latched ? wr_data : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Latched flags.
   genvar flag_idx;
   generate
      for (flag_idx = 0; flag_idx < 8; flag_idx++) begin : g_flag
         logic flag_q;

         logic flag_d;

         wire flag_set;

         wire flag_clr;

         wire flag_hold;

         assign flag_set = set_vec[flag_idx];
         assign flag_clr = clr_mask[flag_idx];
         assign flag_hold = flag_q && !flag_clr;

         // A set arriving in the same cycle as its clear wins, so no event is lost.
         assign flag_d = flag_set || flag_hold;
         assign latched_q[flag_idx] = flag_q;

         always_ff @(posedge mclk) begin
            if (rst) begin
               flag_q <= fault_status_pkg::flags_reset[flag_idx];
            end else if (clk_en) begin
               flag_q <= flag_d;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Live undervoltage flags. No latching: each bit follows its condition one cycle later.
   genvar live_idx;
   generate
      for (live_idx = 0; live_idx < fault_status_pkg::live_count; live_idx++) begin : g_live
         logic live_bit_q;

         logic live_bit_d;

         assign live_bit_d = regulator_uv[live_idx];
         assign live_q[live_idx] = live_bit_q;

         always_ff @(posedge mclk) begin
            if (rst) begin
               live_bit_q <= 1'b0;
            end else if (clk_en) begin
               live_bit_q <= live_bit_d;
            end
         end
      end
   endgenerate

   assign live_word = 8'(live_q) << fault_status_pkg::live_lsb;

   ////////////////////////////////////////////////////////////////////////////
   // Battery edge history. It starts at the normal level, so a battery that is
   // already low when reset ends is reported once.
   assign batt_prev_d = battery_below;

   always_ff @(posedge mclk) begin
      if (rst) begin
         batt_prev_q <= 1'b0;
      end else if (clk_en) begin
         batt_prev_q <= batt_prev_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path. Data is registered and zero after each enabled cycle without a read; while clk_en is low it holds the last value.
   wire [7:0] read_latched_word = read_latched ? latched_q : 8'h00;

   wire [7:0] read_live_word = read_live ? live_word : 8'h00;

   assign rd_data_d = read_latched_word | read_live_word;

   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else if (clk_en) begin
         rd_data <= rd_data_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Detail clear pulse for the memory-load error detail registers.
   assign detail_clear_d = clr_mask[fault_status_pkg::mem_err_bit];

   always_ff @(posedge mclk) begin
      if (rst) begin
         detail_clear <= 1'b0;
      end else if (clk_en) begin
         detail_clear <= detail_clear_d;
      end
   end

endmodule

`default_nettype wire

// *** fault_status_flags_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module fault_status_flags_asserts(input wire logic mclk, rst, clk_en, wr_en, rd_en, detail_clear,
   input wire logic cold_reset_input_n, watchdog_error,
   input wire logic [7:0] addr, wr_data, rd_data, input wire logic [3:0] regulator_uv);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   property p_live;
      clk_en && rd_en && addr == 8'h01 |=> rd_data == {2'h0, $past(regulator_uv, 2), 2'h0};
   endproperty
   a_live: assert property (p_live) else $error("live read wrong");
   property p_clr; clk_en |=> detail_clear == $past(wr_en && addr == 8'h00 && wr_data[4]); endproperty
   a_clr: assert property (p_clr) else $error("detail clear wrong");
   property p_idle; clk_en && !rd_en |=> rd_data == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not zero when idle");
   property p_unmapped; clk_en && rd_en && addr > 8'h01 |=> rd_data == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_reset; disable iff (1'b0) rst |=> rd_data == 8'h00 && !detail_clear; endproperty
   a_reset: assert property (p_reset) else $error("outputs not zero after reset");
   property p_trig;
      clk_en && !cold_reset_input_n ##1 clk_en && !wr_en ##1 clk_en && rd_en && addr == 8'h00 |=> rd_data[3];
   endproperty
   a_trig: assert property (p_trig) else $error("reset trigger flag not latched");
   property p_wdog;
      clk_en && watchdog_error ##1 clk_en && !wr_en ##1 clk_en && rd_en && addr == 8'h00 |=> rd_data[2];
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog flag not latched");
   c_clr: cover property (detail_clear);
   c_live: cover property (rd_en && addr == 8'h01 && regulator_uv != 4'h0);
   c_lat: cover property (rd_en && addr == 8'h00 && rd_data == 8'h00);
endmodule
`default_nettype wire

// *** fault_status_pkg.sv ***
package fault_status_pkg;

   // Register indices within the block's own small address space.
   localparam logic [7:0] latched_six_addr = 8'h00;
   localparam logic [7:0] live_one_addr = 8'h01;
   localparam logic [7:0] flags_reset = 8'h00;

   // Latched register bit positions.
   localparam int batt_bit = 7;
   localparam int ref_lockout_bit = 6;
   localparam int analog_pd_bit = 5;
   localparam int mem_err_bit = 4;
   localparam int rst_trig_bit = 3;
   localparam int wdog_bit = 2;
   localparam int otemp_fault_bit = 1;
   localparam int otemp_warn_bit = 0;

   // Live register: regulators 6 down to 3 sit in bits 5 down to 2.
   localparam int live_lsb = 2;
   localparam int live_count = 4;
   localparam logic [2:0] detail_width = 3'h3;

endpackage

// *** tb_fault_status_flags.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_fault_status_flags;
   logic mclk = 0, rst = 1, clk_en = 1, wr_en, rd_en, detail_clear;
   logic [7:0] addr, wr_data, rd_data, ev = 8'h00;
   logic [3:0] regulator_uv = 4'h0;
   logic [2:0] mem_src = 3'h1;
   int num_errors = 0, n_tests = 0, cyc = 0, seed = 22;
   always #12.5 mclk = ~mclk;
   fault_host host_u(.*);
   fault_status_flags dut_u(.*, .battery_below(ev[7]), .ref_input_lockout(ev[6]),
      .analog_supply_power_down(ev[5]), .ecc_uncorrected(ev[4] && mem_src[0]),
      .nvm_voltage_low(ev[4] && mem_src[1]), .nvm_data_invalid(ev[4] && mem_src[2]),
      .cold_reset_input_n(!ev[3]), .watchdog_error(ev[2]), .otemp_fault(ev[1]), .otemp_warn(ev[0]));
   function automatic logic [7:0] live(input logic [3:0] r); return {2'h0, r, 2'h0}; endfunction
   function automatic logic [7:0] flag(input int b); return 8'h01 << b; endfunction
   task automatic check(input logic [7:0] got, e);
      n_tests++;
      if (got !== e) begin num_errors++; $display("ERROR %0t %h %h", $time, got, e); end
   endtask
   task automatic rd(input logic [7:0] a, e);
      host_u.acc(1'b0, a, 8'h00);
      check(rd_data, e);
   endtask
   task automatic wrap_up;
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge mclk) if (++cyc > 3000) begin num_errors++; wrap_up(); end
   initial begin
      repeat (4) @(posedge mclk);
      #1 rst = 0;
      for (int i = 0; i < 10; i++) begin
         int b;
         b = (i < 8) ? i : 4;
         mem_src = (i < 8) ? 3'h1 : 3'h1 << (i - 7);
         @(posedge mclk) #1 ev = flag(b);
         @(posedge mclk) #1 ev = 8'h00;
         rd(8'h00, flag(b));
         host_u.acc(1'b1, 8'h00, 8'h00);
         check({7'h00, detail_clear}, 8'h00);
         rd(8'h00, flag(b));
         host_u.acc(1'b1, 8'h00, flag(b));
         check({7'h00, detail_clear}, {7'h00, b == 4});
         rd(8'h00, 8'h00);
      end
      @(posedge mclk) #1 ev = 8'h80;
      host_u.acc(1'b1, 8'h00, 8'h80);
      rd(8'h00, 8'h00);
      ev = 8'h00;
      @(posedge mclk) #1 ev = 8'h04;
      host_u.acc(1'b1, 8'h00, 8'h04);
      ev = 8'h00;
      rd(8'h00, 8'h04);
      host_u.acc(1'b1, 8'h01, 8'hff);
      rd(8'h00, 8'h04);
      rd(8'h02, 8'h00);
      host_u.acc(1'b1, 8'h00, 8'h04);
      @(posedge mclk) #1 clk_en = 0;
      ev = 8'h02;
      @(posedge mclk) #1 ev = 8'h00;
      clk_en = 1;
      rd(8'h00, 8'h00);
      $display("latched test end");
      for (int k = 0; k < 11; k++) begin
         @(posedge mclk) #1 regulator_uv = (k == 0) ? 4'hf : (k == 1) ? 4'h0 : 4'($random(seed));
         @(posedge mclk);
         rd(8'h01, live(regulator_uv));
      end
      $display("live test end");
      wrap_up();
   end
endmodule
bind fault_status_flags fault_status_flags_asserts chk_u(.*);
`default_nettype wire
